// [qrs_defs.svh]
// Constants for the quad rate burst SRAM port: widths and beat counts.
// Assumes inclusion by bare name from package and module files.
`ifndef QRS_DEFS_SVH
`define QRS_DEFS_SVH

// ****************************************************************
// Data and address shape
// ****************************************************************
`define QRS_WORD_W     36
`define QRS_BYTE_W     9
`define QRS_NUM_BYTES  4
`define QRS_BURST_W    2
`define QRS_ADDR_W     19
`define QRS_SLOTS      2

// ****************************************************************
// Beat numbers counted from the starting positive rise (beat 0)
// ****************************************************************
`define QRS_CNT_W      4
`define QRS_CNT_RST    4'h0
`define QRS_CNT_STEP   4'h1
`define QRS_WR_FIRST   4'h2
`define QRS_WR_LAST    4'h5
`define QRS_RD_FIRST   4'h5
`define QRS_RD_LAST    4'h8

// ****************************************************************
// Reset values
// ****************************************************************
`define QRS_OE_RST     1'b0
`define QRS_SYNC_RST   2'h0

`endif

// [qrs_pkg.sv]
// Types shared by the burst SRAM port and its storage array.
// Assumes qrs_defs.svh is on the include path.
`default_nettype none
`include "qrs_defs.svh"

package qrs_pkg;
	// Kind of operation started on the previous positive rise
	typedef enum logic [1:0] {
		OP_NONE = 2'b00,
		OP_RD   = 2'b01,
		OP_WR   = 2'b10
	} last_op_t;
endpackage

`default_nettype wire

// [mem_if.sv]
// Carrier between the port controller and its storage array.
// Assumes both ends share one clock.
`timescale 1ns/10ps
`default_nettype none
`include "qrs_defs.svh"

interface mem_if #(
	parameter int AW = `QRS_ADDR_W + `QRS_BURST_W
);
	logic                        we;    // Write this beat
	logic [AW-1:0]               waddr; // Word address of write
	logic [`QRS_WORD_W-1:0]      wdata; // Write word
	logic [`QRS_NUM_BYTES-1:0]   wbe;   // Byte enables, high = write
	logic [AW-1:0]               raddr; // Word address of read
	logic [`QRS_WORD_W-1:0]      rdata; // Read word, combinational

	modport ctrl  (output we, waddr, wdata, wbe, raddr, input rdata);
	modport array (input we, waddr, wdata, wbe, raddr, output rdata);
endinterface

`default_nettype wire

// [sram_array.sv]
// Storage array with per-byte write masking and combinational read.
// Assumes one write per clock at most, driven by the port controller.
`timescale 1ns/10ps
`default_nettype none
`include "qrs_defs.svh"

module sram_array
	import qrs_pkg::*;
#(
	parameter int AW = `QRS_ADDR_W + `QRS_BURST_W
) (
	input wire logic i_clk_sys, // System clock
	mem_if.array     mif        // Array side of carrier
);

	// ****************************************************************
	// Storage
	// ****************************************************************
	// No reset: contents after power-up are undefined, as in a real RAM
	logic [`QRS_WORD_W-1:0] mem [2**AW];
	logic [`QRS_WORD_W-1:0] old_word; // Word before this write
	logic [`QRS_WORD_W-1:0] merged;   // Word after byte merge

	assign old_word = mem[mif.waddr];

	// Each byte takes new data only when its enable is set
	genvar b;
	generate
		for (b = 0; b < `QRS_NUM_BYTES; b++) begin : g_byte
			assign merged[b*`QRS_BYTE_W +: `QRS_BYTE_W] = mif.wbe[b] ?
				mif.wdata[b*`QRS_BYTE_W +: `QRS_BYTE_W] :
				old_word[b*`QRS_BYTE_W +: `QRS_BYTE_W]; // R9
		end
	endgenerate

	// Whole-word store of the merged word
	always_ff @(posedge i_clk_sys) begin
		if (mif.we) begin
			mem[mif.waddr] <= merged;
		end
	end

	// Read sees writes of earlier beats, so data is always current
	assign mif.rdata = mem[mif.raddr];
endmodule

`default_nettype wire

// [quad_rate_sram_port.sv]
// Separate-port four-word burst SRAM: controller, arbitration, I/O.
// Assumes the two input clock rises arrive as alternating one-cycle
// strobes synchronous to i_clk_sys; no strobe means clocks stopped.
// Summary of operation
// R1 - Write data taken on four beats after start
// R2 - Read words launched 2.5 cycles after start
// R3 - Idle ports: inputs ignored, outputs tri-stated
// R4 - Power-up deselected, outputs tri-stated
// R5 - Burst order A, A+1, A+2, A+3
// R6 - Data in and out on both clock rises
// R7 - Select is don't-care right after starting
// R8 - Back-to-back same-type request is ignored
// R9 - Low byte select writes its nine bits
// R10 - All selects high leaves word unchanged
// R11 - Byte selects evaluated on every beat
// R12 - Stopped clocks hold state; park high
// R13 - Both selected: alternate, read first from idle
// R14 - Deselect finishes pending burst first
`timescale 1ns/10ps
`default_nettype none
`include "qrs_defs.svh"

module quad_rate_sram_port
	import qrs_pkg::*;
#(
	parameter int ADDR_W = `QRS_ADDR_W // Burst address width
) (
	input  wire logic                      i_clk_sys,             // Clock
	input  wire logic                      i_rstn,                // Reset
	input  wire logic                      i_k_rise,              // K rise
	input  wire logic                      i_kn_rise,             // K# rise
	input  wire logic                      i_read_port_select_n,  // Rd sel
	input  wire logic                      i_write_port_select_n, // Wr sel
	input  wire logic [ADDR_W-1:0]         i_addr,                // Address
	input  wire logic [`QRS_WORD_W-1:0]    i_d,                   // Wr data
	input  wire logic [`QRS_NUM_BYTES-1:0] i_byte_write_select_n, // Masks
	output logic      [`QRS_WORD_W-1:0]    o_q,                   // Rd data
	output logic                           o_q_oe                 // Drive Q
);

	// ****************************************************************
	// Reset release
	// ****************************************************************
	logic [1:0] rst_sync_q; // Release shift register
	logic       rst_n;      // Synchronised reset for the design

	// Assert at once, release after two clocks
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			rst_sync_q <= `QRS_SYNC_RST;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	// ****************************************************************
	// State
	// ****************************************************************
	localparam int AW = ADDR_W + `QRS_BURST_W; // Word address width

	typedef struct packed {
		logic [`QRS_SLOTS-1:0]                  rd_act;  // Read slot busy
		logic [`QRS_SLOTS-1:0][`QRS_CNT_W-1:0]  rd_cnt;  // Read beat no.
		logic [`QRS_SLOTS-1:0][ADDR_W-1:0]      rd_addr; // Read address
		logic                                   rd_slot; // Next read slot
		logic [`QRS_SLOTS-1:0]                  wr_act;  // Write busy
		logic [`QRS_SLOTS-1:0][`QRS_CNT_W-1:0]  wr_cnt;  // Write beat no.
		logic [`QRS_SLOTS-1:0][ADDR_W-1:0]      wr_addr; // Write address
		logic                                   wr_slot; // Next wr slot
		last_op_t                               last_op; // Prev K start
		logic [`QRS_WORD_W-1:0]                 q;       // Output word
		logic                                   q_oe;    // Output drive
	} state_t;

	// Two slots per port suffice: starts are at least four beats apart
	// and a burst lives at most eight beats.
	state_t q_s; // Registered state
	state_t d_s; // Next state

	logic beat;     // Any clock rise
	logic rd_req;   // Legal read request
	logic wr_req;   // Legal write request
	logic start_rd; // Read starts this rise
	logic start_wr; // Write starts this rise
	logic rd_go;    // A read word launches this beat
	logic wr_go;    // A write word lands this beat

	mem_if #(.AW(AW)) mif (); // Carrier to the array

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		logic [`QRS_CNT_W-1:0] nxt; // Beat number after this rise
		logic [`QRS_CNT_W-1:0] off; // Word offset within burst
		nxt = `QRS_CNT_RST;
		off = `QRS_CNT_RST;
		d_s = q_s;
		rd_go = 1'b0;
		wr_go = 1'b0;
		mif.we = 1'b0;
		mif.waddr = '0;
		mif.wdata = i_d;
		mif.wbe = '0;
		mif.raddr = '0;
		beat = i_k_rise | i_kn_rise; // R6
		// Back-to-back same-type starts are dropped
		rd_req = i_k_rise && !i_read_port_select_n &&
			(q_s.last_op != OP_RD); // R7 R8
		wr_req = i_k_rise && !i_write_port_select_n &&
			(q_s.last_op != OP_WR); // R7 R8
		// A legal read only loses after a read, which rd_req excludes
		start_rd = rd_req; // R13
		start_wr = wr_req && !rd_req; // R13
		// No strobes: everything holds while clocks are stopped
		if (beat) begin
			// Read slots: advance and launch words
			for (int s = 0; s < `QRS_SLOTS; s++) begin
				if (q_s.rd_act[s]) begin
					nxt = q_s.rd_cnt[s] + `QRS_CNT_STEP;
					d_s.rd_cnt[s] = nxt;
					if (nxt >= `QRS_RD_FIRST && nxt <= `QRS_RD_LAST) begin
						off = nxt - `QRS_RD_FIRST;
						rd_go = 1'b1;
						mif.raddr = {q_s.rd_addr[s], off[1:0]}; // R5
					end
					if (nxt == `QRS_RD_LAST) begin
						d_s.rd_act[s] = 1'b0; // R14
					end
				end
			end
			// Write slots: advance and store words
			for (int s = 0; s < `QRS_SLOTS; s++) begin
				if (q_s.wr_act[s]) begin
					nxt = q_s.wr_cnt[s] + `QRS_CNT_STEP;
					d_s.wr_cnt[s] = nxt;
					if (nxt >= `QRS_WR_FIRST && nxt <= `QRS_WR_LAST) begin
						off = nxt - `QRS_WR_FIRST;
						wr_go = 1'b1;
						mif.we = 1'b1; // R1
						mif.waddr = {q_s.wr_addr[s], off[1:0]}; // R5
						mif.wbe = ~i_byte_write_select_n; // R9 R10 R11
					end
					if (nxt == `QRS_WR_LAST) begin
						d_s.wr_act[s] = 1'b0; // R14
					end
				end
			end
			// Output register: launch, else float after a K# rise
			if (rd_go) begin
				d_s.q = mif.rdata; // R2
				d_s.q_oe = 1'b1;
			end else if (i_kn_rise) begin
				d_s.q_oe = 1'b0; // R3 R14
			end
			// New bursts and arbitration history
			if (i_k_rise) begin
				if (start_rd) begin
					d_s.last_op = OP_RD;
					d_s.rd_act[q_s.rd_slot] = 1'b1;
					d_s.rd_cnt[q_s.rd_slot] = `QRS_CNT_RST;
					d_s.rd_addr[q_s.rd_slot] = i_addr;
					d_s.rd_slot = ~q_s.rd_slot;
				end else if (start_wr) begin
					d_s.last_op = OP_WR;
					d_s.wr_act[q_s.wr_slot] = 1'b1;
					d_s.wr_cnt[q_s.wr_slot] = `QRS_CNT_RST;
					d_s.wr_addr[q_s.wr_slot] = i_addr;
					d_s.wr_slot = ~q_s.wr_slot;
				end else begin
					d_s.last_op = OP_NONE; // R3
				end
			end
		end
	end

	// ****************************************************************
	// State register
	// ****************************************************************
	// Power-up leaves both ports idle and Q floating
	always_ff @(posedge i_clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			q_s <= '0; // R4
			q_s.last_op <= OP_NONE;
			q_s.q_oe <= `QRS_OE_RST;
		end else begin
			q_s <= d_s;
		end
	end

	assign o_q = q_s.q;
	assign o_q_oe = q_s.q_oe;

	// ****************************************************************
	// Storage
	// ****************************************************************
	sram_array #(.AW(AW)) sram_array_i (
		.i_clk_sys (i_clk_sys),
		.mif       (mif)
	);

	// ****************************************************************
	// Checks
	// ****************************************************************
	sequence s_rd_launch;
		beat && rd_go;
	endsequence

	sequence s_both_sel;
		i_k_rise && !i_read_port_select_n && !i_write_port_select_n;
	endsequence

	property p_rd_launch;
		@(posedge i_clk_sys) disable iff (!rst_n)
		s_rd_launch |=> o_q_oe && (o_q == $past(mif.rdata));
	endproperty
	a_rd_launch: assert property (p_rd_launch) // R2
		else $error("read word not driven after launch");

	property p_float;
		@(posedge i_clk_sys) disable iff (!rst_n)
		(i_kn_rise && !rd_go) |=> !o_q_oe;
	endproperty
	a_float: assert property (p_float) // R3
		else $error("output driven without a pending read word");

	property p_reset_idle;
		@(posedge i_clk_sys)
		$rose(rst_n) |-> !o_q_oe && (q_s.rd_act == '0) &&
			(q_s.wr_act == '0);
	endproperty
	a_reset_idle: assert property (p_reset_idle) // R4
		else $error("not deselected after reset");

	property p_wr_back;
		@(posedge i_clk_sys) disable iff (!rst_n)
		(i_k_rise && !i_write_port_select_n && q_s.last_op == OP_WR)
			|=> q_s.last_op != OP_WR;
	endproperty
	a_wr_back: assert property (p_wr_back) // R8
		else $error("second back-to-back write was accepted");

	property p_rd_back2;
		@(posedge i_clk_sys) disable iff (!rst_n)
		(i_k_rise && !i_read_port_select_n && q_s.last_op == OP_RD)
			|=> q_s.last_op != OP_RD;
	endproperty
	a_rd_back2: assert property (p_rd_back2) // R8
		else $error("second back-to-back read was accepted");

	property p_arb_idle;
		@(posedge i_clk_sys) disable iff (!rst_n)
		(s_both_sel and (q_s.last_op == OP_NONE)) |=>
			q_s.last_op == OP_RD;
	endproperty
	a_arb_idle: assert property (p_arb_idle) // R13
		else $error("read did not win from idle");

	property p_arb_after_rd;
		@(posedge i_clk_sys) disable iff (!rst_n)
		(s_both_sel and (q_s.last_op == OP_RD)) |=>
			q_s.last_op == OP_WR;
	endproperty
	a_arb_after_rd: assert property (p_arb_after_rd) // R13
		else $error("write did not win after a read");

	property p_byte_mask;
		@(posedge i_clk_sys) disable iff (!rst_n)
		wr_go |-> mif.we && (mif.wbe == ~i_byte_write_select_n);
	endproperty
	a_byte_mask: assert property (p_byte_mask) // R9
		else $error("byte enables do not follow selects");

	property p_no_write_all_high;
		@(posedge i_clk_sys) disable iff (!rst_n)
		(wr_go && (&i_byte_write_select_n)) |-> (mif.wbe == '0);
	endproperty
	a_no_write_all_high: assert property (p_no_write_all_high) // R10
		else $error("word altered with all selects high");

	property p_wr_beats;
		@(posedge i_clk_sys) disable iff (!rst_n)
		start_wr ##1 beat |-> !wr_go || (mif.waddr[1:0] == 2'h3);
	endproperty
	a_wr_beats: assert property (p_wr_beats) // R1
		else $error("write data taken on the K# rise of the start");

	property p_rd_addr_order;
		@(posedge i_clk_sys) disable iff (!rst_n)
		s_rd_launch ##1 (beat && rd_go) |->
			(mif.raddr[1:0] == $past(mif.raddr[1:0]) + 2'h1) ||
			(mif.raddr[1:0] == 2'h0);
	endproperty
	a_rd_addr_order: assert property (p_rd_addr_order) // R5
		else $error("burst words out of order");
endmodule

`default_nettype wire

// [sram_ctrl_model.sv]
// Memory controller model: K/K# strobes, selects, address, write data.
// Assumes the bench calls cyc once per clock, starting on a K strobe.
`timescale 1ns/10ps
`default_nettype none
`include "qrs_defs.svh"

module sram_ctrl_model #(
	parameter int AW = 4 // Burst address width
) (
	input  wire logic                    i_clk_sys, // Clock
	output logic                         o_k_rise,  // K strobe
	output logic                         o_kn_rise, // K# strobe
	output logic                         o_rd_sel_n, // Read select
	output logic                         o_wr_sel_n, // Write select
	output logic [AW-1:0]                o_addr,    // Address
	output logic [`QRS_WORD_W-1:0]       o_d,       // Write word
	output logic [`QRS_NUM_BYTES-1:0]    o_be_n     // Byte selects
);
	// ******
	// Strobes and request lines
	// ******
	bit ph = 1'b1; // Next strobe is K

	// Quiet bus at time zero
	initial begin
		o_k_rise = 1'b0;
		o_kn_rise = 1'b0;
		o_rd_sel_n = 1'b1;
		o_wr_sel_n = 1'b1;
		o_addr = '0;
		o_d = 36'h0;
		o_be_n = 4'hF;
	end

	// One clock; lines with no meaning toggle so stale values never pass
	task automatic cyc(input bit run, sel, input logic rs_n, ws_n,
		input logic [AW-1:0] a, input bit dv,
		input logic [`QRS_WORD_W-1:0] d, input logic [3:0] be);
		@(posedge i_clk_sys);
		o_k_rise <= run && ph;
		o_kn_rise <= run && !ph;
		if (run) begin
			ph = !ph; // Stopped clocks keep phase
		end
		o_rd_sel_n <= sel ? rs_n : ~o_rd_sel_n;
		o_wr_sel_n <= sel ? ws_n : ~o_wr_sel_n;
		o_addr <= sel ? a : ~o_addr;
		o_d <= dv ? d : ~o_d;
		o_be_n <= dv ? be : ~o_be_n;
	endtask
endmodule

`default_nettype wire

// [tb_quad_rate_sram_port.sv]
// Bench for the burst SRAM port: bursts, masks, arbitration, stops.
// Assumes sram_ctrl_model drives every input except clock and reset.
`timescale 1ns/10ps
`default_nettype none
`include "qrs_defs.svh"

module tb_quad_rate_sram_port
	import qrs_pkg::*;
;
	// ******
	// Signals and expectation state
	// ******
	localparam int AW = 4; // Small array keeps the fill short
	logic                     clk = 1'b0;  // System clock
	logic                     rstn = 1'b0; // Reset, active low
	logic                     k_rise;      // K strobe
	logic                     kn_rise;     // K# strobe
	logic                     rd_sel_n;    // Read select
	logic                     wr_sel_n;    // Write select
	logic [AW-1:0]            addr;        // Burst address
	logic [`QRS_WORD_W-1:0]   d;           // Write word
	logic [3:0]               be_n;        // Byte selects
	logic [`QRS_WORD_W-1:0]   q;           // Read word
	logic                     q_oe;        // Read drive
	logic [`QRS_WORD_W-1:0]   ref_m [64];  // Expected contents
	bit                       rv [16];     // Launch due at strobe
	logic [AW+1:0]            ra [16];     // Launch word address
	bit                       wv [16];     // Write beat at strobe
	logic [AW+1:0]            wa [16];     // Write word address
	logic [3:0]               wb [16];     // Write beat selects
	logic [3:0]               bpat [4];    // Selects per burst word
	logic [8:0]               seq = 9'h0;  // Data pattern step
	last_op_t                 last = OP_NONE; // Op of last K rise
	int                       s = 0;       // Strobe number
	int                       pi = 0;      // Slot of last strobe
	bit                       pst = 1'b0;  // Last cycle strobed
	logic                     oe_h = 1'b0; // Last drive seen
	logic [`QRS_WORD_W-1:0]   q_h = 36'h0; // Last word seen
	int                       err_count = 0; // Mismatches
	int                       cmp_count = 0; // Comparisons

	// Clock, 40 ns period
	initial begin
		forever #20 clk = ~clk;
	end

	quad_rate_sram_port #(.ADDR_W(AW)) quad_rate_sram_port_i (
		.i_clk_sys(clk), .i_rstn(rstn), .i_k_rise(k_rise),
		.i_kn_rise(kn_rise), .i_read_port_select_n(rd_sel_n),
		.i_write_port_select_n(wr_sel_n), .i_addr(addr), .i_d(d),
		.i_byte_write_select_n(be_n), .o_q(q), .o_q_oe(q_oe));

	sram_ctrl_model #(.AW(AW)) sram_ctrl_model_i (
		.i_clk_sys(clk), .o_k_rise(k_rise), .o_kn_rise(kn_rise),
		.o_rd_sel_n(rd_sel_n), .o_wr_sel_n(wr_sel_n), .o_addr(addr),
		.o_d(d), .o_be_n(be_n));

	// ******
	// Compare and cycle helpers
	// ******
	task automatic chk_bit(input string n, input logic e, g);
		cmp_count++;
		if (g !== e) begin
			err_count++;
			$display("wrong value %s: expected %0b seen %0b", n, e, g);
		end
	endtask

	task automatic chk_word(input string n, input logic [35:0] e, g);
		cmp_count++;
		if (g !== e) begin
			err_count++;
			$display("wrong value %s: expected %h seen %h", n, e, g);
		end
	endtask

	// One clock: drive, judge the last cycle, then book this one
	task automatic step(input bit run, input logic rs_n, ws_n,
		input logic [AW-1:0] a);
		int i;
		int k;
		bit ks;
		bit dv;
		logic [35:0] dw;
		i = s % 16;
		ks = run && (s % 2 == 0);
		dv = run && wv[i];
		dw = 36'h9A5B3C1D7 ^ {4{seq}};
		sram_ctrl_model_i.cyc(run, ks, rs_n, ws_n, a, dv, dw, wb[i]);
		#1;
		if (pst) begin
			chk_bit("q_oe", rv[pi], q_oe);
			if (rv[pi]) chk_word("q", ref_m[ra[pi]], q);
			rv[pi] = 1'b0;
		end else begin
			chk_bit("q_oe held", oe_h, q_oe);
			chk_word("q held", q_h, q);
		end
		oe_h = q_oe;
		q_h = q;
		if (dv) begin
			for (int b = 0; b < 4; b++)
				if (!wb[i][b]) ref_m[wa[i]][9*b+:9] = dw[9*b+:9];
			seq++;
			wv[i] = 1'b0;
		end
		if (ks) begin
			// Read wins unless it would follow a read
			if (!rs_n && last != OP_RD) begin
				last = OP_RD;
				for (k = 0; k < 4; k++) begin
					rv[(s+5+k)%16] = 1'b1;
					ra[(s+5+k)%16] = {a, 2'(k)};
				end
			end else if (!ws_n && last != OP_WR) begin
				last = OP_WR;
				for (k = 0; k < 4; k++) begin
					wv[(s+2+k)%16] = 1'b1;
					wa[(s+2+k)%16] = {a, 2'(k)};
					wb[(s+2+k)%16] = bpat[k];
				end
			end else begin
				last = OP_NONE;
			end
		end
		pst = run;
		pi = i;
		if (run) s++;
	endtask

	// One K rise with selects, then one K# rise
	task automatic kk(input logic rs_n, ws_n, input logic [AW-1:0] a);
		step(1'b1, rs_n, ws_n, a);
		step(1'b1, 1'b1, 1'b1, a);
	endtask

	task automatic idle(input int n);
		repeat (n) kk(1'b1, 1'b1, 4'h0);
	endtask

	// ******
	// Scenarios
	// ******
	task automatic t_reset();
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		#1;
		chk_bit("q_oe in reset", 1'b0, q_oe);
		chk_word("q in reset", 36'h0, q);
		step(1'b0, 1'b1, 1'b1, 4'h0);
		step(1'b0, 1'b1, 1'b1, 4'h0);
		idle(2);
	endtask

	// Whole words everywhere, writes every other K rise
	task automatic t_fill();
		for (int k = 0; k < 4; k++) bpat[k] = 4'h0;
		for (int a = 0; a < 16; a++) begin
			kk(1'b1, 1'b0, 4'(a));
			idle(1);
		end
		idle(4);
	endtask

	// Pipelined reads keep the drive up across bursts
	task automatic t_reads();
		for (int a = 0; a < 16; a++) begin
			kk(1'b0, 1'b1, 4'(a));
			idle(1);
		end
		idle(5);
	endtask

	// Every single byte select, a word left alone, change per beat
	task automatic t_bytes();
		logic [15:0] pat [2];
		pat[0] = 16'h7BDE;
		pat[1] = 16'hFF0F;
		for (int j = 0; j < 2; j++) begin
			for (int k = 0; k < 4; k++) bpat[k] = pat[j][4*k+:4];
			kk(1'b1, 1'b0, 4'(5 + j));
			idle(1);
		end
		for (int k = 0; k < 4; k++) bpat[k] = 4'h0;
		kk(1'b0, 1'b1, 4'h5);
		idle(1);
		kk(1'b0, 1'b1, 4'h6);
		idle(5);
	endtask

	// Both selected from idle: read, write, read, write
	task automatic t_both();
		repeat (6) kk(1'b0, 1'b0, 4'h8);
		idle(5);
	endtask

	// Same type on consecutive K rises: second one dropped
	task automatic t_b2b();
		kk(1'b0, 1'b1, 4'h9);
		kk(1'b0, 1'b1, 4'hA);
		kk(1'b1, 1'b0, 4'hB);
		kk(1'b1, 1'b0, 4'hC);
		idle(1);
		kk(1'b0, 1'b1, 4'hC);
		idle(5);
	endtask

	// Clocks stop inside a write and a read; state holds
	task automatic t_stop();
		kk(1'b1, 1'b0, 4'hD);
		kk(1'b0, 1'b1, 4'h2);
		repeat (3) step(1'b0, 1'b1, 1'b1, 4'h0);
		kk(1'b1, 1'b1, 4'h0);
		repeat (2) step(1'b0, 1'b1, 1'b1, 4'h0);
		idle(5);
		kk(1'b0, 1'b1, 4'hD);
		idle(5);
	endtask

	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Main sequence
	initial begin
		t_reset();
		t_fill();
		t_reads();
		t_bytes();
		t_both();
		t_b2b();
		t_stop();
		stop_test();
	end
endmodule

`default_nettype wire
